// ---- hdl/psw_pkg.sv ----
/*
  psw_pkg: constants and carrier types for the pump status word bank.
  assumes: a modbus rtu front end that decodes function 0x04 and a 16-bit register address.
*/
package psw_pkg;
  // ----------------------------------------------------------------
  // register addresses and function code
  // ----------------------------------------------------------------
  localparam logic [15:0] PSW_ADDR_SYS = 16'h0103;
  localparam logic [15:0] PSW_ADDR_IN = 16'h0114;
  localparam logic [15:0] PSW_ADDR_OUT = 16'h0115;
  localparam logic [7:0] PSW_FC_READ_INPUT = 8'h04;
  localparam logic [7:0] PSW_EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] PSW_EXC_ILLEGAL_ADDR = 8'h02;
  // ----------------------------------------------------------------
  // system status bit positions
  // ----------------------------------------------------------------
  localparam int PSW_SYS_OVERTEMP = 6;
  localparam int PSW_SYS_STALL = 7;
  localparam int PSW_SYS_BURST = 9;
  localparam int PSW_SYS_LOW_SP = 10;
  localparam int PSW_SYS_HIGH_SP = 11;
  localparam int PSW_SYS_LEVEL = 12;
  localparam logic [15:0] PSW_WORD_RESET = 16'h0000;
  localparam int PSW_NUM_GPO = 4;

  typedef struct packed {
    logic level_alert;
    logic high_sp_range;
    logic low_sp_range;
    logic tube_burst;
    logic motor_stall;
    logic over_temp;
  } psw_faults_t;

  // remote inputs, active low at the pin (pulled to 0v)
  typedef struct packed {
    logic direction_n;
    logic spill_n;
    logic source_empty_n;
    logic dest_full_n;
    logic start_n;
    logic stop_n;
    logic remote_sel_n;
  } psw_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
  } psw_req_t;

  typedef struct packed {
    logic valid;
    logic exc;
    logic [7:0] code;
    logic [15:0] data;
  } psw_rsp_t;
endpackage : psw_pkg

// ---- hdl/psw_sync.sv ----
/*
  psw_sync: three-stage synchroniser with agreement filter for a bus of pins.
  assumes: inputs asynchronous to clk; output changes once stages two and three agree.
*/
`timescale 1ns/100ps
module psw_sync import psw_pkg::*; #(
  parameter int WIDTH = 7,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins and filtered level
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  wire logic [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
  wire logic [WIDTH-1:0] out_next = (s2_reg & agree) | (out_reg & ~agree);

  if (WIDTH < 1) begin : width_check
    $error("psw_sync width must be positive");
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule : psw_sync

// ---- hdl/psw_bank.sv ----
/*
  psw_bank: read-only status word bank (system, input pin, output pin words).
  assumes: a modbus rtu framer hands over one decoded read request per pulse and
  accepts the single-word answer the cycle after; fault and gpo levels come from
  pump logic on clk; remote pins are raw and asynchronous.
*/
// Operation
// (RL1) bit 6 mirrors over-temperature condition
// (RL2) bit 7 mirrors motor stall
// (RL3) bit 9 mirrors tube burst detection
// (RL4) bit 10 low set point out of range
// (RL5) bit 11 high range, bit 12 level
// (RL6) pin words at 0x0114, 0x0115, read-only
// (RL7) pin at 0v reads as 1
// (RL8) inactive output 0, active output 1
// (RL9) function 0x04 returns one 16-bit word
// (RL10) input bit 0 remote control selection
// (RL11) input bit 1 stop, bit 2 start
// (RL12) input bit 3 full, bit 4 empty
// (RL13) bit 5 spill, bit 6 direction
// (RL14) output bits 0-3 mirror gpo designations
// (RL15) unused status bits always read zero
// (RL16) system status word read-only at 0x0103
`timescale 1ns/100ps
module psw_bank import psw_pkg::*; #(
  parameter int NUM_GPO = PSW_NUM_GPO
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pump state, same clock
  input wire psw_faults_t faults,
  input wire logic [NUM_GPO-1:0] gpo_active,
  // remote connector pins, active low
  input wire psw_pins_t pins,
  // register request and answer from the framer
  input wire psw_req_t req,
  output psw_rsp_t rsp
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // the top bit of the output word must stay unused, so 15 outputs is the most served
  if (NUM_GPO < 1 || NUM_GPO > 15) begin : gpo_count_check
    $error("psw_bank gpo count out of range");
  end

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  logic [6:0] pins_sync;
  psw_sync #(.WIDTH(7), .INIT(7'h7f)) psw_sync_inst (
    .clk(clk),
    .rstn(rstn),
    .din(pins),
    .dout(pins_sync)
  );
  // pulled-low pin is active; inversion makes a released pin read 0
  wire logic [6:0] pins_active = ~pins_sync; // see RL7

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  logic [15:0] sys_reg, in_reg, out_reg;
  logic [15:0] sys_next, in_next, out_next;

  // bits 0 to 4 belong to pump logic outside this bank and read zero here
  always_comb begin
    sys_next = PSW_WORD_RESET; // see RL15
    sys_next[PSW_SYS_OVERTEMP] = faults.over_temp; // see RL1
    sys_next[PSW_SYS_STALL] = faults.motor_stall; // see RL2
    sys_next[PSW_SYS_BURST] = faults.tube_burst; // see RL3
    sys_next[PSW_SYS_LOW_SP] = faults.low_sp_range; // see RL4
    sys_next[PSW_SYS_HIGH_SP] = faults.high_sp_range; // see RL5
    sys_next[PSW_SYS_LEVEL] = faults.level_alert; // see RL5
  end

  // bit order follows the struct: remote_sel in bit 0 up to direction in bit 6
  assign in_next = {9'h000, pins_active}; // see RL10 // see RL11 // see RL12 // see RL13 // see RL15
  assign out_next = {{(16-NUM_GPO){1'b0}}, gpo_active}; // see RL8 // see RL14 // see RL15

  // one short register per word, so a read always sees one settled copy
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sys_reg <= PSW_WORD_RESET;
    end else begin
      sys_reg <= sys_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_reg <= PSW_WORD_RESET;
    end else begin
      in_reg <= in_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_reg <= PSW_WORD_RESET;
    end else begin
      out_reg <= out_next;
    end
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // only reads exist; there is no write path so the words cannot be altered
  // exact match only: neighbouring addresses are refused, never aliased
  function automatic logic addr_is(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction : addr_is

  wire logic fc_ok = (req.func == PSW_FC_READ_INPUT); // see RL9
  wire logic hit_sys = addr_is(req.addr, PSW_ADDR_SYS); // see RL16
  wire logic hit_in = addr_is(req.addr, PSW_ADDR_IN); // see RL6
  wire logic hit_out = addr_is(req.addr, PSW_ADDR_OUT); // see RL6
  wire logic addr_ok = hit_sys | hit_in | hit_out;
  wire logic [15:0] sel_word = hit_sys ? sys_reg : hit_in ? in_reg : hit_out ? out_reg : PSW_WORD_RESET;

  psw_rsp_t rsp_reg, rsp_next;

  // ----------------------------------------------------------------
  // answer building
  // ----------------------------------------------------------------
  // refusals carry no data, so a master that ignores the exception flag reads zero
  function automatic psw_rsp_t refusal(input logic [7:0] code);
    psw_rsp_t r;
    r = '0;
    r.valid = 1'b1;
    r.exc = 1'b1;
    r.code = code;
    return r;
  endfunction : refusal

  function automatic psw_rsp_t answer(input logic [15:0] word);
    psw_rsp_t r;
    r = '0;
    r.valid = 1'b1;
    r.code = PSW_FC_READ_INPUT; // see RL9
    r.data = word; // see RL9
    return r;
  endfunction : answer

  always_comb begin
    rsp_next = '0;
    if (req.valid) begin
      if (!fc_ok) begin
        rsp_next = refusal(PSW_EXC_ILLEGAL_FUNC); // see RL9
      end else if (!addr_ok) begin
        rsp_next = refusal(PSW_EXC_ILLEGAL_ADDR); // see RL6
      end else begin
        rsp_next = answer(sel_word);
      end
    end
  end

  // the answer stands for exactly one cycle, then the idle value returns
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp = rsp_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // system and output words follow their same-clock inputs one cycle later
  sys_overtemp_a: assert property (##1 sys_reg[6] == $past(faults.over_temp)) // see RL1
    else $error("overtemp bit wrong");
  sys_stall_a: assert property (##1 sys_reg[7] == $past(faults.motor_stall)) // see RL2
    else $error("stall bit wrong");
  sys_burst_a: assert property (##1 sys_reg[9] == $past(faults.tube_burst)) // see RL3
    else $error("burst bit wrong");
  sys_low_sp_a: assert property (##1 sys_reg[10] == $past(faults.low_sp_range)) // see RL4
    else $error("low sp bit wrong");
  sys_high_level_a: assert property (##1 // see RL5
    sys_reg[12:11] == $past({faults.level_alert, faults.high_sp_range})) else $error("high sp or level bit wrong");
  unused_zero_a: assert property (sys_reg[15:13] == 3'h0 && sys_reg[8] == 1'b0 && sys_reg[5] == 1'b0 // see RL15
    && in_reg[15:7] == 9'h000 && out_reg[15:NUM_GPO] == '0) else $error("unused bit set");
  gpo_mirror_a: assert property (##1 out_reg[NUM_GPO-1:0] == $past(gpo_active)) // see RL14
    else $error("gpo bit wrong");

  // pin checks wait six quiet cycles: three sync stages, the filter and the word register,
  // with one spare for a pin already held active through reset
  pin_active_a: assert property ($stable(pins)[*6] |-> in_reg[6:0] == ~pins) // see RL7
    else $error("pin polarity wrong");
  remote_sel_a: assert property ($stable(pins)[*6] |-> // see RL10
    in_reg[0] == !pins.remote_sel_n) else $error("remote selection bit wrong");
  stop_start_a: assert property ($stable(pins)[*6] |-> // see RL11
    in_reg[2:1] == ~{pins.start_n, pins.stop_n}) else $error("stop or start bit wrong");
  full_empty_a: assert property ($stable(pins)[*6] |-> // see RL12
    in_reg[4:3] == ~{pins.source_empty_n, pins.dest_full_n}) else $error("full or empty bit wrong");
  spill_dir_a: assert property ($stable(pins)[*6] |-> // see RL13
    in_reg[6:5] == ~{pins.direction_n, pins.spill_n}) else $error("spill or direction bit wrong");

  read_in_a: assert property (req.valid && fc_ok && hit_in |=> // see RL6
    rsp.valid && !rsp.exc && rsp.data == $past(in_reg)) else $error("input word read wrong");
  read_out_a: assert property (req.valid && fc_ok && hit_out |=> // see RL6
    rsp.valid && !rsp.exc && rsp.data == $past(out_reg)) else $error("output word read wrong");
  read_sys_a: assert property (req.valid && fc_ok && hit_sys |=> // see RL16
    rsp.valid && rsp.data == $past(sys_reg)) else $error("system word read wrong");
  answer_once_a: assert property (req.valid |=> rsp.valid) else $error("request not answered"); // see RL9
  rsp_single_a: assert property (!req.valid |=> rsp == '0) else $error("answer held too long"); // see RL9
  good_code_a: assert property (req.valid && fc_ok && addr_ok |=> // see RL9
    rsp.code == PSW_FC_READ_INPUT && !rsp.exc) else $error("good read refused");
  bad_func_a: assert property (req.valid && !fc_ok |=> rsp.exc && rsp.code == PSW_EXC_ILLEGAL_FUNC) // see RL9
    else $error("wrong function accepted");
  bad_addr_a: assert property (req.valid && fc_ok && !addr_ok |=> // see RL6
    rsp.exc && rsp.code == PSW_EXC_ILLEGAL_ADDR) else $error("wrong address accepted");
  refusal_data_a: assert property (rsp.exc |-> rsp.data == 16'h0000) // see RL9
    else $error("refusal carries data");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  read_out_c: cover property (req.valid && fc_ok && hit_out);
  read_sys_c: cover property (req.valid && fc_ok && hit_sys ##1 rsp.data != 16'h0000);
  bad_addr_c: cover property (req.valid && fc_ok && !addr_ok);
  bad_func_c: cover property (req.valid && !fc_ok);
  pin_active_c: cover property (in_reg[0] && in_reg[6]);
endmodule : psw_bank

// ---- bench/psw_master.sv ----
/*
  psw_master: modbus master stand-in that issues one decoded read per call.
  assumes: the bank answers within three cycles; requests change on the falling edge.
*/
`timescale 1ns/100ps
module psw_master import psw_pkg::*; (
  // clock
  input wire logic clk,
  // request out, answer in
  output psw_req_t req,
  input wire psw_rsp_t rsp
);
  initial req = '0;
  // one pulse, then a bounded wait for the single word
  task automatic rd(input logic [7:0] f, input logic [15:0] a, output psw_rsp_t r);
    int n;
    r = '0;
    @(negedge clk);
    req = '{valid: 1'b1, func: f, addr: a};
    @(negedge clk);
    // released fields show the inverse so a stale value never reads as good
    req = '{valid: 1'b0, func: ~f, addr: ~a};
    for (n = 0; n < 3 && !r.valid; n++) begin
      if (rsp.valid === 1'b1) r = rsp;
      else @(negedge clk);
    end
  endtask : rd
endmodule : psw_master

// ---- bench/testbench.sv ----
/*
  testbench: drives fault, gpo and pin levels and reads the three words back.
  assumes: psw_bank with four outputs; remote pins need five cycles to settle, and the bench waits eight.
*/
`timescale 1ns/100ps
module testbench import psw_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  psw_faults_t faults = '0;
  logic [3:0] gpo_active = '0;
  psw_pins_t pins = '1;
  psw_req_t req;
  psw_rsp_t rsp;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  int i;
  localparam logic [15:0] SYS_BIT [6] = '{16'h0040, 16'h0080, 16'h0200, 16'h0400, 16'h0800, 16'h1000};

  psw_bank psw_bank_inst (.clk(clk), .rstn(rstn), .faults(faults), .gpo_active(gpo_active), .pins(pins),
    .req(req), .rsp(rsp));
  psw_master psw_master_inst (.clk(clk), .req(req), .rsp(rsp));

  initial forever #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic rd_chk(input logic [7:0] f, input logic [15:0] a, input logic [7:0] code,
                        input logic [15:0] data);
    psw_rsp_t r;
    psw_rsp_t e;
    e = '{valid: 1'b1, exc: (code != 8'h04), code: code, data: data};
    psw_master_inst.rd(f, a, r);
    // data of an address refusal is forced to zero here, so only the code counts there
    if (code == 8'h02) r.data = '0;
    num_checks++;
    if (r !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t func %h addr %h got %h exp %h", $time, f, a, r, e);
    end
  endtask : rd_chk

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd_chk(8'h04, 16'h0103, 8'h04, 16'h0000);
    for (i = 0; i < 6; i++) begin
      faults = psw_faults_t'(6'h01 << i);
      rd_chk(8'h04, 16'h0103, 8'h04, SYS_BIT[i]);
    end
    faults = '1;
    rd_chk(8'h04, 16'h0103, 8'h04, 16'h1ec0);
    $display("test system word done");
    for (i = 0; i < 7; i++) begin
      pins = psw_pins_t'(~(7'h01 << i));
      repeat (8) @(negedge clk);
      rd_chk(8'h04, 16'h0114, 8'h04, 16'h0001 << i);
    end
    pins = '0;
    repeat (8) @(negedge clk);
    rd_chk(8'h04, 16'h0114, 8'h04, 16'h007f);
    $display("test input word done");
    for (i = 0; i < 4; i++) begin
      gpo_active = 4'h1 << i;
      rd_chk(8'h04, 16'h0115, 8'h04, 16'h0001 << i);
    end
    gpo_active = '1;
    rd_chk(8'h04, 16'h0115, 8'h04, 16'h000f);
    $display("test output word done");
    rd_chk(8'h03, 16'h0103, 8'h01, 16'h0000);
    rd_chk(8'h06, 16'h0114, 8'h01, 16'h0000);
    rd_chk(8'h04, 16'h0116, 8'h02, 16'h0000);
    rd_chk(8'h04, 16'h0102, 8'h02, 16'h0000);
    $display("test refusals done");
    finish_test();
  end
endmodule : testbench
